// ### rtl/drs_core.sv
// dpll reference selection, loop mode, phase offset and system clock lock control
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module drs_core
  import drs_pkg::*;
#(
  parameter int NREF = 8,
  parameter int NPROF = 8
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reference monitors and system clock detector, asynchronous
  input wire logic [NREF-1:0] ref_valid_in,
  input wire logic [NREF-1:0] ref_freq_prof_in,
  input wire logic sysclk_pd_edge,
  input wire logic sysclk_in_thresh,
  // loop controls to the datapath
  output logic [2:0] loop_ref_idx,
  output logic [1:0] loop_state,
  output logic [31:0] loop_phase,
  output logic [31:0] slew_limit,
  output logic slewing,
  output logic sysclk_bypass,
  output logic sysclk_locked,
  output logic cal_start,
  output logic sync_start,
  output logic dpll_power_down,
  output logic dpll_soft_reset
);
  initial begin
    if (NREF < 1 || NREF > 8) $error("drs_core: NREF must be 1..8");
    if (NPROF != 8) $error("drs_core: NPROF must be 8");
  end

  // register storage
  logic [31:0] ctrl_q;
  logic [NREF-1:0] force_q;
  logic [31:0] offset_q, off_inc_q, slew_q, syn_phase_q;
  logic [15:0] lock_cnt_q;
  logic [31:0] assign_q;
  logic [31:0] prof_q [NPROF*PROF_WORDS];
  logic [31:0] step_acc_q;
  logic [15:0] edge_cnt_q;
  logic locked_q;
  drs_state_t state_q;
  logic [2:0] cur_ref_q;
  logic [31:0] slew_cnt_q;
  logic slewing_q;
  logic cal_q, sync_q;

  // asynchronous inputs except ref_freq_prof_in pass three flops; second and third must agree
  logic [NREF-1:0] vs1_q, vs2_q, vs3_q, valid_q;
  logic [1:0] pd_s1_q, pd_s2_q, pd_s3_q;
  logic pd_q, thr_q, pd_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vs1_q <= '0;
      vs2_q <= '0;
      vs3_q <= '0;
      valid_q <= '0;
    end else begin
      vs1_q <= ref_valid_in;
      vs2_q <= vs1_q;
      vs3_q <= vs2_q;
      for (int i = 0; i < NREF; i++) begin
        if (vs2_q[i] == vs3_q[i]) valid_q[i] <= vs3_q[i];
      end
    end
  end

  // phase detector edge and threshold flag synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_s1_q <= '0;
      pd_s2_q <= '0;
      pd_s3_q <= '0;
      pd_q <= 1'b0;
      thr_q <= 1'b0;
      pd_prev_q <= 1'b0;
    end else begin
      pd_s1_q <= {sysclk_in_thresh, sysclk_pd_edge};
      pd_s2_q <= pd_s1_q;
      pd_s3_q <= pd_s2_q;
      if (pd_s2_q[0] == pd_s3_q[0]) pd_q <= pd_s3_q[0];
      if (pd_s2_q[1] == pd_s3_q[1]) thr_q <= pd_s3_q[1];
      pd_prev_q <= pd_q;
    end
  end

  // decoded controls
  drs_sel_mode_t sel_mode;
  drs_loop_mode_t loop_mode;
  logic [2:0] user_ref;
  assign sel_mode = drs_sel_mode_t'(ctrl_q[CTRL_SEL_LSB +: 2]);
  assign loop_mode = drs_loop_mode_t'(ctrl_q[CTRL_LOOP_LSB +: 2]);
  assign user_ref = ctrl_q[CTRL_USER_LSB +: 3];

  // effective validity: forcing wins, holdover loop masks all
  logic [NREF-1:0] eff_valid;
  always_comb begin
    eff_valid = valid_q | force_q;
    if (loop_mode == LOOP_HOLDOVER) eff_valid = '0;
  end

  // priority per reference comes from its profile; manual assignment overrides detection
  logic [NREF*4-1:0] ref_prio;
  genvar g;
  generate
    for (g = 0; g < NREF; g++) begin : g_prio
      logic [2:0] prof_sel;
      assign prof_sel = assign_q[g*4+3] ? assign_q[g*4 +: 3] : 3'(ref_freq_prof_in[g] ? g : 0);
      assign ref_prio[g*4 +: 4] = prof_q[32'(prof_sel)*PROF_WORDS + 4][3:0];
    end
  endgenerate

  drs_pick_t pick;
  drs_prio_pick #(.NREF(NREF)) u_pick (
    .valid(eff_valid),
    .prio(ref_prio),
    .pick(pick)
  );

  // target selection per reference-selection mode
  logic want_lock;
  logic [2:0] want_ref;
  logic user_ok;
  assign user_ok = eff_valid[user_ref];
  always_comb begin
    want_lock = 1'b0;
    want_ref = cur_ref_q;
    case (sel_mode)
      SEL_AUTO: begin
        want_lock = pick.found && ctrl_q[CTRL_AUTO_BIT];
        want_ref = pick.ref_idx;
      end
      SEL_FALLBACK: begin
        want_lock = user_ok || pick.found;
        want_ref = user_ok ? user_ref : pick.ref_idx;
      end
      SEL_HOLDOVER: begin
        want_lock = user_ok;
        want_ref = user_ref;
      end
      SEL_MANUAL: begin
        want_lock = loop_mode != LOOP_HOLDOVER;
        want_ref = user_ref;
      end
      default: begin
        want_lock = 1'b0;
        want_ref = cur_ref_q;
      end
    endcase
    if (loop_mode == LOOP_FREERUN) want_lock = 1'b0;
  end

  // loop state machine; having tracked once, losing the target means holdover
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_FREERUN;
      cur_ref_q <= '0;
    end else if (ctrl_q[CTRL_RST_BIT] || ctrl_q[CTRL_PDN_BIT]) begin
      state_q <= ST_FREERUN;
    end else begin
      case (state_q)
        ST_FREERUN: begin
          if (loop_mode == LOOP_HOLDOVER) state_q <= ST_HOLDOVER;
          else if (want_lock) begin
            state_q <= ST_LOCKED;
            cur_ref_q <= want_ref;
          end
        end
        ST_LOCKED: begin
          if (loop_mode == LOOP_FREERUN) state_q <= ST_FREERUN;
          else if (!want_lock) state_q <= ST_HOLDOVER;
          else cur_ref_q <= want_ref;
        end
        ST_HOLDOVER: begin
          if (loop_mode == LOOP_FREERUN) state_q <= ST_FREERUN;
          else if (want_lock) begin
            state_q <= ST_LOCKED;
            cur_ref_q <= want_ref;
          end
        end
        default: state_q <= ST_FREERUN;
      endcase
    end
  end

  // apb decode; zero wait states, unmapped addresses answer with an error
  logic wr_en, rd_en, prof_hit, known;
  logic [5:0] prof_idx;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign prof_hit = paddr >= ADDR_PROF_BASE;
  assign prof_idx = 6'(paddr[7:2] - ADDR_PROF_BASE[7:2]);
  always_comb begin
    case (paddr)
      ADDR_CTRL, ADDR_FORCE, ADDR_OFFSET, ADDR_OFF_INC, ADDR_SLEW, ADDR_SYN_PHASE,
      ADDR_LOCK_CNT, ADDR_CMD, ADDR_STATUS, ADDR_PHASE, ADDR_ASSIGN: known = 1'b1;
      default: known = prof_hit && paddr[1:0] == 2'b00;
    endcase
  end

  // control register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
      force_q <= '0;
      offset_q <= '0;
      off_inc_q <= '0;
      slew_q <= SLEW_RESET;
      syn_phase_q <= '0;
      lock_cnt_q <= LOCK_CNT_RESET;
      assign_q <= '0;
    end else if (wr_en) begin
      case (paddr)
        ADDR_CTRL: ctrl_q <= {20'h0, pwdata[11:0]};
        ADDR_FORCE: force_q <= pwdata[NREF-1:0];
        ADDR_OFFSET: offset_q <= pwdata;
        ADDR_OFF_INC: off_inc_q <= pwdata;
        ADDR_SLEW: slew_q <= pwdata;
        ADDR_SYN_PHASE: syn_phase_q <= pwdata;
        ADDR_LOCK_CNT: lock_cnt_q <= pwdata[15:0];
        ADDR_ASSIGN: assign_q <= pwdata;
        default: ;
      endcase
    end
  end

  // profile storage, eight profiles by eight words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NPROF*PROF_WORDS; i++) prof_q[i] <= '0;
    end else if (wr_en && prof_hit && paddr[1:0] == 2'b00) begin
      prof_q[prof_idx] <= pwdata;
    end
  end

  // offset step accumulator; only stepped while locked, cleared outside tracking
  logic inc_cmd;
  assign inc_cmd = wr_en && paddr == ADDR_CMD && pwdata[CMD_INC_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) step_acc_q <= '0;
    else if (state_q != ST_LOCKED) step_acc_q <= '0;
    else if (inc_cmd) step_acc_q <= step_acc_q + off_inc_q;
  end

  // one-cycle calibration and sync strobes; sequencing is the host's job
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      cal_q <= wr_en && paddr == ADDR_CMD && pwdata[CMD_CAL_BIT];
      sync_q <= wr_en && paddr == ADDR_CMD && pwdata[CMD_SYNC_BIT];
    end
  end

  // system clock lock detect: count consecutive in-threshold edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_cnt_q <= '0;
      locked_q <= 1'b0;
    end else if (cal_q || ctrl_q[CTRL_DIRECT_BIT]) begin
      edge_cnt_q <= '0;
      locked_q <= ctrl_q[CTRL_DIRECT_BIT]; // no pll to lock when bypassed
    end else if (pd_q && !pd_prev_q) begin
      if (!thr_q) begin
        edge_cnt_q <= '0;
        locked_q <= 1'b0;
      end else if (edge_cnt_q + 16'h1 >= lock_cnt_q) begin
        edge_cnt_q <= lock_cnt_q;
        locked_q <= 1'b1;
      end else begin
        edge_cnt_q <= edge_cnt_q + 16'h1;
      end
    end
  end

  // slew limiting window after each reference change while locked; zero limit means none
  logic ref_change;
  assign ref_change = state_q == ST_LOCKED && want_lock && want_ref != cur_ref_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slewing_q <= 1'b0;
      slew_cnt_q <= '0;
    end else if (ref_change && slew_q != 32'h0) begin
      slewing_q <= 1'b1;
      slew_cnt_q <= slew_q;
    end else if (slewing_q) begin
      slew_cnt_q <= slew_cnt_q - 32'h1;
      if (slew_cnt_q <= 32'h1 || slew_q == 32'h0) slewing_q <= 1'b0;
    end
  end

  // output registers; phase source depends on whether a reference is tracked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_ref_idx <= '0;
      loop_state <= '0;
      loop_phase <= '0;
      slew_limit <= '0;
      slewing <= 1'b0;
      sysclk_bypass <= 1'b0;
      sysclk_locked <= 1'b0;
      cal_start <= 1'b0;
      sync_start <= 1'b0;
      dpll_power_down <= 1'b0;
      dpll_soft_reset <= 1'b0;
    end else begin
      loop_ref_idx <= cur_ref_q;
      loop_state <= state_q;
      if (state_q == ST_LOCKED) loop_phase <= offset_q + step_acc_q;
      else if (state_q == ST_FREERUN) loop_phase <= syn_phase_q;
      slew_limit <= slew_q;
      slewing <= slewing_q;
      sysclk_bypass <= ctrl_q[CTRL_DIRECT_BIT];
      sysclk_locked <= locked_q;
      cal_start <= cal_q;
      sync_start <= sync_q;
      dpll_power_down <= ctrl_q[CTRL_PDN_BIT];
      dpll_soft_reset <= ctrl_q[CTRL_RST_BIT];
    end
  end

  // read mux
  logic [31:0] rd_d;
  always_comb begin
    rd_d = '0;
    case (paddr)
      ADDR_CTRL: rd_d = ctrl_q;
      ADDR_FORCE: rd_d = 32'(force_q);
      ADDR_OFFSET: rd_d = offset_q;
      ADDR_OFF_INC: rd_d = off_inc_q;
      ADDR_SLEW: rd_d = slew_q;
      ADDR_SYN_PHASE: rd_d = syn_phase_q;
      ADDR_LOCK_CNT: rd_d = {16'h0, lock_cnt_q};
      ADDR_ASSIGN: rd_d = assign_q;
      ADDR_STATUS: rd_d = {8'h0, 8'(valid_q), 8'(eff_valid), 1'b0, slewing_q, locked_q,
                           cur_ref_q, 2'(state_q)};
      ADDR_PHASE: rd_d = step_acc_q;
      // unaligned profile reads are refused, so they must return zero too
      default: rd_d = (prof_hit && paddr[1:0] == 2'b00) ? prof_q[prof_idx] : 32'h0;
    endcase
  end

  // apb answer: ready in the access cycle, data registered in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !known;
      if (psel && !penable && !pwrite) prdata <= rd_d;
    end
  end
endmodule

// ### rtl/drs_pkg.sv
// package: register map, field layout and enumerations for the dpll reference selector
package drs_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FORCE = 8'h04;
  localparam logic [7:0] ADDR_OFFSET = 8'h08;
  localparam logic [7:0] ADDR_OFF_INC = 8'h0c;
  localparam logic [7:0] ADDR_SLEW = 8'h10;
  localparam logic [7:0] ADDR_SYN_PHASE = 8'h14;
  localparam logic [7:0] ADDR_LOCK_CNT = 8'h18;
  localparam logic [7:0] ADDR_CMD = 8'h1c;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_PHASE = 8'h24;
  localparam logic [7:0] ADDR_PROF_BASE = 8'h40;
  localparam logic [7:0] ADDR_ASSIGN = 8'h28;
  // ctrl field positions
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_LOOP_LSB = 2;
  localparam int CTRL_USER_LSB = 4;
  localparam int CTRL_PDN_BIT = 8;
  localparam int CTRL_RST_BIT = 9;
  localparam int CTRL_AUTO_BIT = 10;
  localparam int CTRL_DIRECT_BIT = 11;
  // cmd bits
  localparam int CMD_INC_BIT = 0;
  localparam int CMD_CAL_BIT = 1;
  localparam int CMD_SYNC_BIT = 2;
  // profile entry: word 0 period, 1 inner tol, 2 outer tol, 3 timers, 4 priority, 5 ratio
  localparam int PROF_WORDS = 8;
  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0400;
  localparam logic [15:0] LOCK_CNT_RESET = 16'h0010;
  localparam logic [31:0] SLEW_RESET = 32'h0000_0000;
  // reference selection modes
  typedef enum logic [1:0] {SEL_AUTO, SEL_FALLBACK, SEL_HOLDOVER, SEL_MANUAL} drs_sel_mode_t;
  // loop modes
  typedef enum logic [1:0] {LOOP_AUTO, LOOP_FREERUN, LOOP_HOLDOVER} drs_loop_mode_t;
  // loop state reported to software
  typedef enum logic [1:0] {ST_FREERUN, ST_LOCKED, ST_HOLDOVER} drs_state_t;
  // choice handed from the selector to the loop
  typedef struct packed {
    logic found;
    logic [2:0] ref_idx;
  } drs_pick_t;
endpackage

// ### rtl/drs_prio_pick.sv
// priority picker: lowest priority value wins among valid references, ties to lower index
`timescale 1ns/1ps
module drs_prio_pick
  import drs_pkg::*;
#(
  parameter int NREF = 8
) (
  // candidates
  input wire logic [NREF-1:0] valid,
  input wire logic [NREF*4-1:0] prio,
  // result
  output drs_pick_t pick
);
  initial begin
    if (NREF < 1 || NREF > 8) $error("drs_prio_pick: NREF must be 1..8");
  end

  // linear scan; eight entries keep the comparator chain short
  always_comb begin
    logic [3:0] best;
    best = 4'hf;
    pick = '0;
    for (int i = 0; i < NREF; i++) begin
      if (valid[i] && (!pick.found || prio[i*4 +: 4] < best)) begin
        pick.found = 1'b1;
        pick.ref_idx = 3'(i);
        best = prio[i*4 +: 4];
      end
    end
  end
endmodule

// ### tb/drs_core_properties.sv
// port checker for the reference selector
`timescale 1ns/1ps
module drs_core_properties
  import drs_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // loop side
  input wire logic [1:0] loop_state,
  input wire logic [31:0] loop_phase,
  input wire logic [31:0] slew_limit,
  input wire logic slewing,
  input wire logic sysclk_bypass,
  input wire logic sysclk_locked,
  input wire logic cal_start,
  input wire logic sync_start
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // zero wait states
  property p_rdy; psel && penable |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing");
  property p_rdy_only; pready |-> psel && penable; endproperty
  a_rdy_only: assert property (p_rdy_only) else $error("stray ready");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  // refused reads return zero
  property p_err_zero; pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("refused read data");
  property p_state; loop_state != 2'h3; endproperty
  a_state: assert property (p_state) else $error("illegal loop state");
  property p_cal; cal_start |=> !cal_start; endproperty
  a_cal: assert property (p_cal) else $error("calibrate not a pulse");
  property p_sync; sync_start |=> !sync_start; endproperty
  a_sync: assert property (p_sync) else $error("sync not a pulse");
  property p_byp; sysclk_bypass |-> ##[0:3] sysclk_locked; endproperty
  a_byp: assert property (p_byp) else $error("bypass not locked");
  // a zero limit never opens a switch window
  property p_slew; slew_limit == 0 && $past(slew_limit) == 0 |-> !slewing; endproperty
  a_slew: assert property (p_slew) else $error("slewing while off");
  property p_hold; loop_state == ST_HOLDOVER [*2] |-> $stable(loop_phase); endproperty
  a_hold: assert property (p_hold) else $error("phase moved in holdover");
endmodule

bind drs_core drs_core_properties i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .loop_state(loop_state), .loop_phase(loop_phase),
  .slew_limit(slew_limit), .slewing(slewing), .sysclk_bypass(sysclk_bypass),
  .sysclk_locked(sysclk_locked), .cal_start(cal_start), .sync_start(sync_start));

// ### tb/drs_ref_model.sv
// reference monitor and system clock detector model
`timescale 1ns/1ps
module drs_ref_model (
  // bench control
  input wire logic pclk,
  input wire logic [7:0] want,
  input wire logic pd_run,
  // monitor outputs
  output logic [7:0] ref_valid_in,
  output logic sysclk_pd_edge,
  output logic sysclk_in_thresh
);
  logic [1:0] div_q = 2'h0;
  logic tog_q = 1'b0;
  // validity is what the bench asks for
  assign ref_valid_in = want;
  assign sysclk_in_thresh = pd_run;
  // detector edge every eight cycles, none while stopped
  assign sysclk_pd_edge = tog_q;
  always @(posedge pclk) begin
    if (pd_run) begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) tog_q <= !tog_q;
    end
  end
endmodule

// ### tb/drs_core_tb_top.sv
// self-checking bench for the reference selector
`timescale 1ns/1ps
module drs_core_tb_top
  import drs_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, pd_run;
  logic slewing, sysclk_bypass, sysclk_locked, cal_start, sync_start;
  logic dpll_power_down, dpll_soft_reset, sysclk_pd_edge, sysclk_in_thresh;
  logic [7:0] paddr, want, ref_valid_in, hint;
  logic [31:0] pwdata, prdata, loop_phase, slew_limit, rd;
  logic [2:0] loop_ref_idx;
  logic [1:0] loop_state;
  logic [1:0] seen_q = 2'h0;
  int error_cnt, tests_run;

  drs_core i_drs_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_valid_in(ref_valid_in), .ref_freq_prof_in(hint),
    .sysclk_pd_edge(sysclk_pd_edge), .sysclk_in_thresh(sysclk_in_thresh),
    .loop_ref_idx(loop_ref_idx), .loop_state(loop_state), .loop_phase(loop_phase),
    .slew_limit(slew_limit), .slewing(slewing), .sysclk_bypass(sysclk_bypass),
    .sysclk_locked(sysclk_locked), .cal_start(cal_start), .sync_start(sync_start),
    .dpll_power_down(dpll_power_down), .dpll_soft_reset(dpll_soft_reset));
  drs_ref_model i_drs_ref_model (.pclk(pclk), .want(want), .pd_run(pd_run),
    .ref_valid_in(ref_valid_in), .sysclk_pd_edge(sysclk_pd_edge),
    .sysclk_in_thresh(sysclk_in_thresh));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // pulses are one cycle, so latch them
  always @(posedge pclk) seen_q <= seen_q | {sync_start, cal_start};

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one transfer; request held until ready is seen in the access cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // ready and data are read at the rising edge itself; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wst(input logic [1:0] s);
    for (int n = 0; n < 300 && loop_state !== s; n++) @(posedge pclk);
  endtask

  task automatic t_regs();
    apb(1'b0, ADDR_CTRL, 0);
    chk(rd, CTRL_RESET);
    apb(1'b0, ADDR_LOCK_CNT, 0);
    chk(rd, {16'h0, LOCK_CNT_RESET});
    apb(1'b0, ADDR_SLEW, 0);
    chk(rd, SLEW_RESET);
    apb(1'b0, 8'h30, 0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
  endtask
  // two valid at once; priorities differ through manual assignment, then through the detection hint
  task automatic t_auto();
    apb(1'b1, 8'h90, 32'h3);
    apb(1'b1, 8'hf0, 32'h1);
    apb(1'b1, ADDR_ASSIGN, 32'h00d0_0a00);
    cyc(20);
    chk(loop_state, ST_FREERUN);
    want <= 8'h24;
    wst(ST_LOCKED);
    chk(loop_state, ST_LOCKED);
    chk(loop_ref_idx, 3'h5);
    // detection hint now maps refs to their own profiles; equal priorities would pick ref 2
    hint <= 8'h24;
    apb(1'b1, ADDR_ASSIGN, 32'h0);
    cyc(10);
    chk(loop_ref_idx, 3'h5);
  endtask
  task automatic t_fallback();
    apb(1'b1, ADDR_SLEW, 32'h14);
    apb(1'b1, ADDR_CTRL, 32'h411);
    cyc(10);
    chk(loop_ref_idx, 3'h5);
    want <= 8'h26;
    for (int n = 0; n < 300 && slewing !== 1'b1; n++) @(posedge pclk);
    chk(slewing, 1'b1);
    chk(slew_limit, 32'h14);
    cyc(40);
    chk(loop_ref_idx, 3'h1);
    chk(slewing, 1'b0);
    apb(1'b1, ADDR_SLEW, 0);
  endtask
  task automatic t_manual();
    apb(1'b1, ADDR_CTRL, 32'h463);
    cyc(20);
    chk(loop_state, ST_LOCKED);
    chk(loop_ref_idx, 3'h6);
  endtask
  task automatic t_hold_sel();
    apb(1'b1, ADDR_CTRL, 32'h412);
    cyc(20);
    chk(loop_ref_idx, 3'h1);
    want <= 8'h24;
    wst(ST_HOLDOVER);
    chk(loop_state, ST_HOLDOVER);
  endtask
  task automatic t_loop();
    apb(1'b1, ADDR_CTRL, 32'h404);
    cyc(20);
    chk(loop_state, ST_FREERUN);
    apb(1'b1, ADDR_SYN_PHASE, 32'h55);
    cyc(5);
    chk(loop_phase, 32'h55);
    apb(1'b1, ADDR_CTRL, 32'h408);
    wst(ST_HOLDOVER);
    chk(loop_state, ST_HOLDOVER);
  endtask
  task automatic t_force();
    want <= 8'h00;
    // let the dropped references clear the synchroniser before leaving holdover
    cyc(10);
    apb(1'b1, ADDR_CTRL, 32'h400);
    apb(1'b1, ADDR_FORCE, 32'h10);
    wst(ST_LOCKED);
    chk(loop_ref_idx, 3'h4);
    apb(1'b1, ADDR_OFFSET, 32'h100);
    cyc(5);
    chk(loop_phase, 32'h100);
    apb(1'b1, ADDR_SYN_PHASE, 32'h77);
    cyc(5);
    chk(loop_phase, 32'h100);
    apb(1'b1, ADDR_OFF_INC, 32'h20);
    apb(1'b1, ADDR_CMD, 32'h1);
    cyc(5);
    chk(loop_state, ST_LOCKED);
    apb(1'b0, ADDR_PHASE, 0);
    chk(rd, 32'h20);
    chk(loop_phase, 32'h120);
  endtask
  // calibrate after configuring, sync once the clock is present
  task automatic t_sysclk();
    apb(1'b1, ADDR_LOCK_CNT, 32'h4);
    apb(1'b1, ADDR_CMD, 32'h2);
    pd_run <= 1'b1;
    cyc(20);
    chk(sysclk_locked, 1'b0);
    cyc(60);
    chk(sysclk_locked, 1'b1);
    apb(1'b1, ADDR_CMD, 32'h4);
    apb(1'b1, ADDR_CTRL, 32'hf00);
    cyc(5);
    chk(seen_q, 2'h3);
    chk({dpll_power_down, dpll_soft_reset, sysclk_bypass, sysclk_locked}, 4'hf);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    error_cnt = 0;
    tests_run = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    want = 8'h0;
    pd_run = 1'b0;
    hint = 8'h0;
    cyc(10);
    presetn <= 1'b1;
    t_regs();
    t_auto();
    t_fallback();
    t_manual();
    t_hold_sel();
    t_loop();
    t_force();
    t_sysclk();
    final_report();
  end
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    #(50 * 20000);
    error_cnt++;
    final_report();
  end
endmodule
